// ### pkg/switch_protection_defines.svh
/*
 Named constants of the switch protection and diagnostics block.
 Assumes a 100 MHz core clock. All protection timers count slow ticks.
*/
`ifndef SWITCH_PROTECTION_DEFINES_SVH
`define SWITCH_PROTECTION_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define TICK_NS 10000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_W 10
`define TMR_W 8
`define RETRY_TICKS 8'h0A
`define COOL_01_TICKS 8'h0A
`define COOL_10_TICKS 8'h32
`define COOL_11_TICKS 8'hC8
`define INRUSH_00_TICKS 8'h02
`define INRUSH_01_TICKS 8'h05
`define INRUSH_10_TICKS 8'h0A
`define INRUSH_11_TICKS 8'h14
`define LATCH_SEL 2'h0
`define RESISTIVE_SEL 2'h0
`define CRATE_HI 7
`define CRATE_LO 4
`define LOW_CURRENT_CODE 10'h00A
`define DECAY_SHIFT 4
`define ACC_TRIP_LSB 8
`define ST_ABS 0
`define ST_REL 1
`define ST_OC 2
`define ST_FUSE 3
`define ST_LATCH 4
`define ST_OL_OFF 5
`define ST_BSHORT 6
`define ST_HOLD 7
`endif

// ### pkg/switch_protection_pkg.sv
/*
 Types of the switch protection and diagnostics block.
 Assumes nothing beyond the defines header.
*/
package switch_protection_pkg;
	typedef enum logic [2:0] {
		CH_OFF,
		CH_INRUSH,
		CH_ON,
		CH_COOL,
		CH_LATCH
	} chan_state_t;
endpackage

// ### design/switch_protection_diagnostics.sv
/*
 Per-channel protection and diagnostic fault logic of a dual high-side
 switch: energy fuse, overlimit delay, cooldown or latch-off, thermal
 faults, inrush handling, overcurrent, reverse battery, sense scaling and
 off-state open-load / battery-short detection.
 Assumes all inputs synchronous to core_clk; ADC codes and comparator
 results come from the analog front end; configuration is held outside.
*/
`timescale 1ns/1ns
`include "switch_protection_defines.svh"

//Contract
//- No trip while current below nominal setting
//- Trip off when accumulated energy exceeds threshold
//- Above max current, shut down after delay
//- After fuse trip, cool down then retry
//- Cooldown select 00 latches off until re-enable
//- Thermal fault on absolute or relative limit
//- Absolute fault clears after hysteresis drop
//- Relative fault clears after retry time
//- Capacitive mode limits current during inrush window
//- Resistive mode trips above inrush threshold
//- After inrush, trip at overcurrent threshold
//- Retry holds fault until output rises
//- Output never rising keeps fault indefinitely; hold clears when command drops
//- Reverse battery forces switch on
//- Low-current enable selects low sense ratio
//- Gain bit multiplies sense voltage by eight
//- Off-state open load sets flag and pin
//- Off-state detection enables selected pull-up
//- Off-state indication follows live comparator
//- Battery-short check pulls down, sets flag
//- Fault turns off only affected channel, reports
//- Re-enable only after retry and faults cleared
module switch_protection_diagnostics
	import switch_protection_pkg::*;
(
	input wire logic core_clk, // Core clock
	input wire logic rst, // Synchronous reset
	input wire logic reverse_battery, // Reverse supply present
	input wire logic [9:0] controller_temp, // Controller temperature
	input wire logic [9:0] absolute_temp_limit, // Absolute FET limit
	input wire logic [9:0] relative_temp_limit, // FET minus controller
	input wire logic [9:0] temp_hysteresis, // Absolute clear margin
	input wire logic [1:0] switch_state, // Commanded on per channel
	input wire logic [1:0][9:0] load_current_result, // Current code
	input wire logic [1:0][9:0] fet_temp, // FET temperature
	input wire logic [1:0][9:0] nominal_current_setting, // Fuse rating
	input wire logic [1:0][15:0] energy_trip_threshold, // Fuse energy
	input wire logic [1:0][9:0] max_measurable_current, // Overlimit
	input wire logic [1:0][7:0] overlimit_shutdown_delay, // In ticks
	input wire logic [1:0][1:0] cooldown_period_select, // 00 latches
	input wire logic [1:0][7:0] current_limit_config, // Charge rate
	input wire logic [1:0][1:0] capacitive_load_select, // 00 resistive
	input wire logic [1:0][1:0] inrush_window_select, // Window length
	input wire logic [1:0][9:0] inrush_threshold_setting, // Inrush trip
	input wire logic [1:0][9:0] overcurrent_threshold, // Main trip
	input wire logic [1:0] on_state_low_current_enable, // Low ratio
	input wire logic [1:0] sense_gain_x8_enable, // ADC gain request
	input wire logic [1:0] off_state_openload_enable, // Off detection
	input wire logic [1:0][1:0] pullup_strength_select, // Pull-up size
	input wire logic [1:0] battery_short_check_enable, // Pulldown test
	input wire logic [1:0] openload_comp, // Output above threshold
	input wire logic [1:0] output_risen, // Output above supply-1.8 V
	input wire logic [1:0] fault_indication_mask, // Blocks pin
	output logic [1:0] fet_enable, // Gate drive on
	output logic [1:0] current_limit_active, // Charge limiting on
	output logic [1:0][3:0] charge_rate_level, // Limit slope
	output logic [1:0] sense_enable, // Current sensing usable
	output logic [1:0] sense_ratio_low, // Ratio 1200 instead of 5000
	output logic [1:0] sense_gain_x8, // ADC input times eight
	output logic [1:0] pullup_enable, // Off-state pull-up source
	output logic [1:0][1:0] pullup_strength, // Pull-up size
	output logic [1:0] pulldown_enable, // Battery-short pulldown
	output logic [1:0][7:0] channel_fault_status, // Readable faults
	output logic fault_pin // High while any unmasked fault except battery short
);
	logic [`TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	logic [1:0] ind;

	// Slow tick shared by every channel timer
	always_comb begin
		tick = (tick_cnt_q == `TICK_W'(`TICK_CYC - 1));
		tick_cnt_d = tick ? '0 : tick_cnt_q + `TICK_W'(1);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	assign fault_pin = |(ind & ~fault_indication_mask);

	for (genvar g = 0; g < 2; g++) begin : g_ch
		chan_state_t st_q, st_d;
		logic [`TMR_W-1:0] tmr_q, tmr_d, ovl_q, ovl_d, rel_tmr_q, rel_tmr_d;
		logic [23:0] acc_q, acc_d;
		logic abs_q, abs_d, rel_q, rel_d, oc_q, oc_d, fuse_q, fuse_d;
		logic hold_q, hold_d, bs_q, bs_d, ol_q, ol_d;
		logic [7:0] stat_q, stat_d;
		logic [9:0] cur;
		logic [19:0] sq;
		logic [24:0] acc_sum;
		logic [10:0] cool_sum;
		logic [9:0] tdiff;
		logic req, run, therm, cap, fuse_trip, oc_trip, ol_act;
		logic [`TMR_W-1:0] cool_ticks, inrush_ticks;

		always_comb begin
			cur = load_current_result[g];
			sq = cur * cur;
			req = switch_state[g] | reverse_battery;
			run = (st_q == CH_INRUSH) || (st_q == CH_ON);
			therm = abs_q | rel_q;
			cap = capacitive_load_select[g] != `RESISTIVE_SEL;
			case (cooldown_period_select[g])
				2'h1: cool_ticks = `COOL_01_TICKS;
				2'h2: cool_ticks = `COOL_10_TICKS;
				default: cool_ticks = `COOL_11_TICKS;
			endcase
			case (inrush_window_select[g])
				2'h0: inrush_ticks = `INRUSH_00_TICKS;
				2'h1: inrush_ticks = `INRUSH_01_TICKS;
				2'h2: inrush_ticks = `INRUSH_10_TICKS;
				default: inrush_ticks = `INRUSH_11_TICKS;
			endcase

			// Thermal faults act in any state
			tdiff = fet_temp[g] - controller_temp;
			cool_sum = {1'b0, fet_temp[g]} + {1'b0, temp_hysteresis};
			abs_d = abs_q;
			if (fet_temp[g] > absolute_temp_limit) begin
				abs_d = 1'b1;
			end else if (cool_sum <= {1'b0, absolute_temp_limit}) begin
				abs_d = 1'b0;
			end
			rel_d = rel_q;
			rel_tmr_d = rel_tmr_q;
			if (!rel_q && fet_temp[g] > controller_temp &&
					tdiff > relative_temp_limit) begin
				rel_d = 1'b1;
				rel_tmr_d = `RETRY_TICKS;
			end else if (rel_q && tick) begin
				if (rel_tmr_q <= `TMR_W'(1)) begin
					rel_d = 1'b0;
					rel_tmr_d = '0;
				end else begin
					rel_tmr_d = rel_tmr_q - `TMR_W'(1);
				end
			end

			// While running, energy integrates only above nominal, else bleeds away
			acc_sum = {1'b0, acc_q} + {5'h00, sq};
			acc_d = acc_q;
			if (run && tick) begin
				if (cur > nominal_current_setting[g]) begin
					acc_d = acc_sum[24] ? '1 : acc_sum[23:0];
				end else begin
					acc_d = acc_q - (acc_q >> `DECAY_SHIFT);
				end
			end
			ovl_d = '0;
			if (run && cur > max_measurable_current[g]) begin
				ovl_d = (tick && ovl_q != '1) ? ovl_q + `TMR_W'(1) : ovl_q;
			end
			fuse_trip = (acc_q[23:`ACC_TRIP_LSB] > energy_trip_threshold[g]) ||
				(cur > max_measurable_current[g] &&
				ovl_q >= overlimit_shutdown_delay[g]);
			if (st_q == CH_INRUSH) begin
				oc_trip = !cap && cur > inrush_threshold_setting[g];
			end else begin
				oc_trip = cur >= overcurrent_threshold[g];
			end

			st_d = st_q;
			tmr_d = tmr_q;
			oc_d = oc_q;
			fuse_d = fuse_q;
			hold_d = hold_q;
			case (st_q)
				CH_OFF: begin
					if (req && !therm) begin
						st_d = CH_INRUSH;
						tmr_d = inrush_ticks;
						acc_d = '0;
					end
				end
				CH_INRUSH, CH_ON: begin
					if (!req) begin
						st_d = CH_OFF;
					end else if (therm) begin
						st_d = CH_COOL;
						tmr_d = '0;
					end else if (fuse_trip) begin
						fuse_d = 1'b1;
						tmr_d = cool_ticks;
						if (cooldown_period_select[g] == `LATCH_SEL) begin
							st_d = CH_LATCH;
						end else begin
							st_d = CH_COOL;
						end
					end else if (oc_trip) begin
						oc_d = 1'b1;
						st_d = CH_COOL;
						tmr_d = `RETRY_TICKS;
					end else if (st_q == CH_INRUSH && tick) begin
						if (tmr_q <= `TMR_W'(1)) begin
							st_d = CH_ON;
						end else begin
							tmr_d = tmr_q - `TMR_W'(1);
						end
					end
				end
				CH_COOL: begin
					if (tick && tmr_q != '0) begin
						tmr_d = tmr_q - `TMR_W'(1);
					end
					if (tmr_q == '0 && !therm) begin
						hold_d = oc_q | fuse_q;
						oc_d = 1'b0;
						fuse_d = 1'b0;
						acc_d = '0;
						tmr_d = inrush_ticks;
						st_d = req ? CH_INRUSH : CH_OFF;
					end
				end
				CH_LATCH: begin
					// Controller must drop the command to release
					if (!switch_state[g] && !therm) begin
						fuse_d = 1'b0;
						acc_d = '0;
						st_d = CH_OFF;
					end
				end
				default: st_d = CH_OFF;
			endcase
			// Stays set until the output rises or the command drops
			if (hold_q && ((run && output_risen[g]) || !req)) begin
				hold_d = 1'b0;
			end

			ol_act = !fet_enable[g] && off_state_openload_enable[g];
			ol_d = ol_act && openload_comp[g];
			bs_d = bs_q;
			if (!ol_act || !battery_short_check_enable[g]) begin
				bs_d = 1'b0;
			end else if (openload_comp[g]) begin
				bs_d = 1'b1;
			end

			stat_d = '0;
			stat_d[`ST_ABS] = abs_q;
			stat_d[`ST_REL] = rel_q;
			stat_d[`ST_OC] = oc_q;
			stat_d[`ST_FUSE] = fuse_q;
			stat_d[`ST_LATCH] = st_q == CH_LATCH;
			stat_d[`ST_OL_OFF] = ol_q;
			stat_d[`ST_BSHORT] = bs_q;
			stat_d[`ST_HOLD] = hold_q;
		end

		always_ff @(posedge core_clk) begin
			if (rst) begin
				st_q <= CH_OFF;
				tmr_q <= '0;
				ovl_q <= '0;
				rel_tmr_q <= '0;
				acc_q <= '0;
				abs_q <= 1'b0;
				rel_q <= 1'b0;
				oc_q <= 1'b0;
				fuse_q <= 1'b0;
				hold_q <= 1'b0;
				bs_q <= 1'b0;
				ol_q <= 1'b0;
				stat_q <= '0;
			end else begin
				st_q <= st_d;
				tmr_q <= tmr_d;
				ovl_q <= ovl_d;
				rel_tmr_q <= rel_tmr_d;
				acc_q <= acc_d;
				abs_q <= abs_d;
				rel_q <= rel_d;
				oc_q <= oc_d;
				fuse_q <= fuse_d;
				hold_q <= hold_d;
				bs_q <= bs_d;
				ol_q <= ol_d;
				stat_q <= stat_d;
			end
		end

		// Reverse supply overrides command to spare the body diode
		assign fet_enable[g] = reverse_battery | run;
		assign current_limit_active[g] = (st_q == CH_INRUSH) && cap;
		assign charge_rate_level[g] =
			current_limit_config[g][`CRATE_HI:`CRATE_LO];
		assign sense_enable[g] = run && !hold_q;
		assign sense_ratio_low[g] = on_state_low_current_enable[g] &&
			cur < `LOW_CURRENT_CODE;
		assign sense_gain_x8[g] = sense_gain_x8_enable[g];
		assign pullup_enable[g] = ol_act &&
			!battery_short_check_enable[g];
		assign pullup_strength[g] = pullup_strength_select[g];
		assign pulldown_enable[g] = ol_act &&
			battery_short_check_enable[g];
		assign channel_fault_status[g] = stat_q;
		assign ind[g] = fuse_q | oc_q | therm | hold_q | ol_q |
			(st_q == CH_LATCH) | (st_q == CH_COOL);
	end
endmodule // switch_protection_diagnostics

// ### verification/load_model.sv
/*
 Load and output-node model seen by both channels.
 Assumes the bench sets the fault conditions of each output.
*/
`timescale 1ns/1ns
module load_model (
	input wire logic [1:0] fet_enable, // Gate drive
	input wire logic [1:0] pullup_enable, // Pull-up source on
	input wire logic [1:0] pulldown_enable, // Pulldown on
	input wire logic [1:0] short_gnd, // Output shorted low
	input wire logic [1:0] short_bat, // Output shorted high
	input wire logic [1:0] open_load, // Load missing
	output logic [1:0] output_risen, // Output near supply
	output logic [1:0] openload_comp // Output above threshold
);
	// A grounded output never rises, so the hold lasts until the command drops
	assign output_risen = fet_enable & ~short_gnd;
	// Open load floats up on the pull-up only; a short wins the pulldown
	assign openload_comp = ~fet_enable & (short_bat |
		(open_load & pullup_enable & ~pulldown_enable));
endmodule // load_model

// ### verification/switch_protection_assertions.sv
/*
 Port checker of the protection block.
 Assumes binding to every instance of the block.
*/
`timescale 1ns/1ns
module switch_protection_checker (
	input wire logic core_clk, // Clock
	input wire logic rst, // Reset
	input wire logic reverse_battery, // Reverse supply
	input wire logic [9:0] absolute_temp_limit, // Limit
	input wire logic [1:0][9:0] fet_temp, // FET temperature
	input wire logic [1:0][9:0] load_current_result, // Current
	input wire logic [1:0][9:0] overcurrent_threshold, // Trip
	input wire logic [1:0][9:0] inrush_threshold_setting, // Trip
	input wire logic [1:0] on_state_low_current_enable, // Low ratio
	input wire logic [1:0] sense_gain_x8_enable, // Gain
	input wire logic [1:0][1:0] pullup_strength_select, // Size
	input wire logic [1:0][7:0] current_limit_config, // Rate
	input wire logic [1:0][1:0] capacitive_load_select, // Mode
	input wire logic [1:0] fault_indication_mask, // Mask
	input wire logic [1:0] fet_enable, // Gate
	input wire logic [1:0] current_limit_active, // Limiting
	input wire logic [1:0][3:0] charge_rate_level, // Rate
	input wire logic [1:0] sense_ratio_low, // Ratio
	input wire logic [1:0] sense_gain_x8, // Gain
	input wire logic [1:0][1:0] pullup_strength, // Size
	input wire logic fault_pin // Pin
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_REV_ON: assert property (reverse_battery |-> fet_enable == 2'h3)
		else $error("reverse supply left a channel off");
	AST_GAIN: assert property (sense_gain_x8 == sense_gain_x8_enable)
		else $error("gain output wrong");
	AST_RATIO: assert property (sense_ratio_low[0] ==
		(on_state_low_current_enable[0] && load_current_result[0] < 10'h00A))
		else $error("sense ratio wrong");
	AST_PU_SIZE: assert property (pullup_strength == pullup_strength_select)
		else $error("pull-up size wrong");
	AST_RATE: assert property (charge_rate_level[0] == current_limit_config[0][7:4])
		else $error("charge rate wrong");
	AST_LIM_CAP: assert property (current_limit_active[0] |->
		capacitive_load_select[0] != 2'h0) else $error("limit in resistive");
	// Fault flag registers first, then the channel state leaves run
	AST_THERM: assert property (fet_temp[0] > absolute_temp_limit &&
		!reverse_battery |-> ##2 !fet_enable[0])
		else $error("hot channel on");
	AST_OC: assert property (fet_enable[0] && !current_limit_active[0] &&
		!reverse_battery && inrush_threshold_setting[0] < overcurrent_threshold[0]
		&& load_current_result[0] >= overcurrent_threshold[0] |=> !fet_enable[0])
		else $error("overcurrent not tripped");
	AST_MASK: assert property (fault_indication_mask == 2'h3 |-> !fault_pin)
		else $error("masked fault on pin");
	COV_ON: cover property ($rose(fet_enable[0]));
	COV_PIN: cover property ($rose(fault_pin));
	COV_LIM: cover property (current_limit_active[0]);
endmodule // switch_protection_checker
bind switch_protection_diagnostics switch_protection_checker u_chk (.*);

// ### verification/switch_protection_diagnostics_tb_top.sv
/*
 Directed bench of the protection block with a load model.
 Assumes the tick of 1000 core cycles from the defines header.
*/
`timescale 1ns/1ns
module switch_protection_diagnostics_tb_top;
	logic core_clk, rst, reverse_battery, fault_pin;
	logic [9:0] controller_temp, absolute_temp_limit;
	logic [9:0] relative_temp_limit, temp_hysteresis;
	logic [1:0] switch_state, on_state_low_current_enable, sense_gain_x8_enable;
	logic [1:0] off_state_openload_enable, battery_short_check_enable;
	logic [1:0] openload_comp, output_risen, fault_indication_mask;
	logic [1:0][9:0] load_current_result, fet_temp, nominal_current_setting;
	logic [1:0][9:0] max_measurable_current, inrush_threshold_setting;
	logic [1:0][9:0] overcurrent_threshold;
	logic [1:0][15:0] energy_trip_threshold;
	logic [1:0][7:0] overlimit_shutdown_delay, current_limit_config;
	logic [1:0][1:0] cooldown_period_select, capacitive_load_select;
	logic [1:0][1:0] inrush_window_select, pullup_strength_select;
	logic [1:0] fet_enable, current_limit_active, sense_enable, sense_ratio_low;
	logic [1:0] sense_gain_x8, pullup_enable, pulldown_enable;
	logic [1:0] short_gnd, short_bat, open_load;
	logic [1:0][3:0] charge_rate_level;
	logic [1:0][1:0] pullup_strength;
	logic [1:0][7:0] channel_fault_status;
	int failures, samples_checked;
	switch_protection_diagnostics u_switch_protection_diagnostics (.*);
	load_model u_load_model (.fet_enable(fet_enable),
		.pullup_enable(pullup_enable), .pulldown_enable(pulldown_enable),
		.short_gnd(short_gnd), .short_bat(short_bat), .open_load(open_load),
		.output_risen(output_risen), .openload_comp(openload_comp));
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task give_verdict;
		$display("compared %0d mismatched %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		cyc(90000);
		failures++;
		give_verdict();
	end
	initial begin
		{rst, reverse_battery, switch_state, short_gnd, short_bat} = 0;
		{open_load, on_state_low_current_enable, sense_gain_x8_enable} = 0;
		{off_state_openload_enable, battery_short_check_enable} = 0;
		{fault_indication_mask, inrush_window_select} = 0;
		controller_temp = 10'h100;
		absolute_temp_limit = 10'h180;
		relative_temp_limit = 10'h3FF;
		temp_hysteresis = 10'h020;
		load_current_result = {2{10'h010}};
		fet_temp = {2{10'h100}};
		nominal_current_setting = {2{10'h3FF}};
		max_measurable_current = {2{10'h3FF}};
		inrush_threshold_setting = {2{10'h280}};
		overcurrent_threshold = {2{10'h300}};
		energy_trip_threshold = {2{16'hFFFF}};
		overlimit_shutdown_delay = {2{8'h02}};
		current_limit_config = {2{8'h50}};
		cooldown_period_select = {2{2'h1}};
		capacitive_load_select = {2'h0, 2'h1};
		pullup_strength_select = {2'h1, 2'h2};
		rst = 1;
		cyc(5);
		rst = 0;
		chk("fet_rst", 8'h00, fet_enable);
		switch_state = 2'h1;
		cyc(2);
		chk("fet_on", 8'h01, fet_enable);
		chk("limit", 8'h01, current_limit_active[0]);
		cyc(3000);
		load_current_result[0] = 10'h300;
		cyc(3);
		chk("oc_fet", 8'h00, fet_enable);
		chk("oc_flag", 8'h04, channel_fault_status[0] & 8'h04);
		chk("oc_pin", 8'h01, fault_pin);
		load_current_result[0] = 10'h010;
		short_gnd[0] = 1;
		cyc(12000);
		chk("retry_fet", 8'h01, fet_enable);
		chk("hold_pin", 8'h01, fault_pin);
		short_gnd[0] = 0;
		cyc(3);
		chk("risen_pin", 8'h00, fault_pin);
		chk("risen_sns", 8'h01, sense_enable[0]);
		$display("overcurrent test done");
		fet_temp[0] = 10'h200;
		cyc(3);
		chk("th_fet", 8'h00, fet_enable);
		chk("th_flag", 8'h01, channel_fault_status[0] & 8'h01);
		fet_temp[0] = 10'h170;
		cyc(3000);
		chk("th_hys", 8'h00, fet_enable);
		fet_temp[0] = 10'h150;
		cyc(20);
		chk("th_clr", 8'h01, fet_enable);
		$display("thermal test done");
		cyc(3000);
		cooldown_period_select[0] = 2'h0;
		max_measurable_current[0] = 10'h200;
		load_current_result[0] = 10'h250;
		cyc(4000);
		chk("lat_fet", 8'h00, fet_enable);
		chk("lat_flag", 8'h18, channel_fault_status[0] & 8'h18);
		load_current_result[0] = 10'h010;
		cyc(15000);
		chk("lat_hold", 8'h00, fet_enable);
		switch_state = 2'h0;
		cyc(2);
		switch_state = 2'h1;
		cyc(2);
		chk("lat_rel", 8'h01, fet_enable);
		$display("latch test done");
		switch_state = 2'h0;
		cyc(2);
		reverse_battery = 1;
		cyc(2);
		chk("rev", 8'h03, fet_enable);
		reverse_battery = 0;
		off_state_openload_enable = 2'h1;
		open_load[0] = 1;
		cyc(4);
		chk("pu_en", 8'h01, pullup_enable[0]);
		chk("ol_flag", 8'h20, channel_fault_status[0] & 8'h20);
		chk("ol_pin", 8'h01, fault_pin);
		fault_indication_mask = 2'h1;
		cyc(2);
		chk("ol_mask", 8'h00, fault_pin);
		fault_indication_mask = 2'h0;
		battery_short_check_enable[0] = 1;
		cyc(4);
		chk("pd_en", 8'h01, pulldown_enable[0]);
		chk("bs_open", 8'h00, channel_fault_status[0] & 8'h40);
		short_bat[0] = 1;
		cyc(4);
		chk("bs_set", 8'h40, channel_fault_status[0] & 8'h40);
		{short_bat, open_load, battery_short_check_enable} = 0;
		cyc(4);
		chk("ol_live", 8'h00, channel_fault_status[0] & 8'h20);
		chk("ol_lpin", 8'h00, fault_pin);
		$display("off-state test done");
		sense_gain_x8_enable = 2'h2;
		on_state_low_current_enable = 2'h1;
		load_current_result[0] = 10'h009;
		cyc(1);
		chk("gain", 8'h02, sense_gain_x8);
		chk("ratio_lo", 8'h01, sense_ratio_low[0]);
		load_current_result[0] = 10'h00A;
		cyc(1);
		chk("ratio_hi", 8'h00, sense_ratio_low[0]);
		$display("sense test done");
		fault_indication_mask = 2'h2;
		switch_state = 2'h2;
		load_current_result[1] = 10'h290;
		cyc(3);
		chk("inr_fet", 8'h00, fet_enable);
		chk("inr_flag", 8'h04, channel_fault_status[1] & 8'h04);
		chk("inr_mask", 8'h00, fault_pin);
		switch_state = 2'h0;
		load_current_result[1] = 10'h010;
		$display("inrush test done");
		relative_temp_limit = 10'h040;
		fet_temp[0] = 10'h150;
		cyc(2);
		fet_temp[0] = 10'h100;
		switch_state = 2'h1;
		cyc(3);
		chk("rel_flag", 8'h02, channel_fault_status[0] & 8'h02);
		chk("rel_ref", 8'h00, fet_enable);
		cyc(8000);
		chk("rel_hold", 8'h00, fet_enable);
		cyc(3000);
		chk("rel_clr", 8'h01, fet_enable);
		chk("rel_bit", 8'h00, channel_fault_status[0] & 8'h02);
		$display("relative thermal test done");
		nominal_current_setting[0] = 10'h100;
		energy_trip_threshold[0] = 16'h0800;
		max_measurable_current[0] = 10'h3FF;
		cooldown_period_select[0] = 2'h1;
		load_current_result[0] = 10'h200;
		cyc(2000);
		chk("fuse_early", 8'h01, fet_enable);
		cyc(2000);
		chk("fuse_fet", 8'h00, fet_enable);
		chk("fuse_flag", 8'h08, channel_fault_status[0] & 8'h18);
		load_current_result[0] = 10'h010;
		cyc(7000);
		chk("cool_hold", 8'h00, fet_enable);
		cyc(4000);
		chk("cool_retry", 8'h01, fet_enable);
		$display("fuse test done");
		give_verdict();
	end
endmodule // switch_protection_diagnostics_tb_top
